// [rtl/crcreg_engine.v]
// CRC engine special-function registers with bit reversal and flash auto-check
`timescale 1ns/10ps
`include "crcreg_consts.vh"
module crcreg_engine (
  input wire core_clk_i,
  input wire rst_i,
  input wire [7:0] sfr_page_i,
  input wire [7:0] sfr_addr_i,
  input wire [7:0] sfr_wdata_i,
  input wire sfr_wr_i,
  input wire sfr_rd_i,
  output reg [7:0] sfr_rdata_o,
  output wire cpu_stall_o,
  output reg flash_rd_o,
  output reg [15:0] flash_addr_o,
  input wire [7:0] flash_data_i,
  input wire flash_valid_i
);
  // Flash walk states
  localparam ST_IDLE = 2'h0;
  localparam ST_REQ = 2'h1;
  localparam ST_WAIT = 2'h2;

  reg [15:0] result_q;
  reg [15:0] result_d;
  reg result_byte_pointer_q;
  reg init_value_select_q;
  reg [7:0] bit_reverse_reg_q;
  reg [7:0] data_input_q;
  reg [7:0] start_block_field_q;
  reg [7:0] block_count_field_q;
  reg auto_check_enable_q;
  reg [1:0] state_q;
  reg [15:0] remain_q;
  reg [7:0] fold_byte;
  wire [15:0] folded;
  wire [7:0] reversed_byte;
  wire [7:0] result_sel_byte;

  wire page_hit = (sfr_page_i == `CRCREG_SFR_PAGE);
  wire wr = sfr_wr_i & page_hit;
  wire rd = sfr_rd_i & page_hit;
  wire wr_in = wr & (sfr_addr_i == `CRCREG_ADDR_DATA_INPUT);
  wire wr_cn0 = wr & (sfr_addr_i == `CRCREG_ADDR_CONTROL_ZERO);
  wire acc_port = (wr | rd) & (sfr_addr_i == `CRCREG_ADDR_RESULT_PORT);
  wire wr_port = wr & (sfr_addr_i == `CRCREG_ADDR_RESULT_PORT);
  // One decoded strobe per register
  wire wr_flip = wr & (sfr_addr_i == `CRCREG_ADDR_BIT_REVERSE);
  wire wr_start = wr & (sfr_addr_i == `CRCREG_ADDR_START_BLOCK);
  wire wr_count = wr & (sfr_addr_i == `CRCREG_ADDR_BLOCK_COUNT);
  wire wr_cn1 = wr & (sfr_addr_i == `CRCREG_ADDR_CONTROL_ONE);
  wire auto_busy = (state_q != ST_IDLE);
  // A fetched byte is folded in the cycle its valid strobe arrives
  wire walk_fold = (state_q == ST_WAIT) & flash_valid_i;
  wire walk_last = (remain_q == 16'h0001);
  wire preset_all_one = sfr_wdata_i[`CRCREG_BIT_VALSEL];

  // Port reads and writes both land on the byte the pointer selects
  assign result_sel_byte = result_byte_pointer_q ? result_q[15:8] : result_q[7:0];

  // Processor holds while the flash walk runs
  assign cpu_stall_o = auto_busy;

  // Flash bytes and bus writes share one fold network
  always @* begin
    fold_byte = auto_busy ? flash_data_i : sfr_wdata_i;
  end

  crcreg_byte_step u_step (
    .crc_i(result_q),
    .byte_i(fold_byte),
    .crc_o(folded)
  );

  // Pure wiring; the byte is stored mirrored so a read needs no extra logic
  genvar b;
  generate
    for (b = 0; b < 8; b = b + 1) begin : g_rev
      assign reversed_byte[b] = sfr_wdata_i[7 - b];
    end
  endgenerate

  always @* begin
    result_d = result_q;
    // A flash byte outranks bus writes, which software keeps off the bus during a stall
    if (walk_fold) begin
      result_d = folded;
    end else if (wr_cn0 && sfr_wdata_i[`CRCREG_BIT_INIT]) begin
      result_d = preset_all_one ? `CRCREG_PRESET_ONE : `CRCREG_PRESET_ZERO;
    end else if (wr_in) begin
      result_d = folded;
    end else if (wr_port) begin
      if (result_byte_pointer_q) begin
        result_d = {sfr_wdata_i, result_q[7:0]};
      end else begin
        result_d = {result_q[15:8], sfr_wdata_i};
      end
    end
  end

  // Result and pointer
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      result_q <= `CRCREG_PRESET_ZERO;
      result_byte_pointer_q <= 1'b0;
    end else begin
      result_q <= result_d;
      // Pointer write and port access in one cycle cannot occur on one bus
      if (wr_cn0) begin
        result_byte_pointer_q <= sfr_wdata_i[`CRCREG_BIT_PTR];
      end else if (acc_port) begin
        result_byte_pointer_q <= ~result_byte_pointer_q;
      end
    end
  end

  // Configuration registers
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      init_value_select_q <= 1'b0;
      bit_reverse_reg_q <= `CRCREG_RESET_BYTE;
      data_input_q <= `CRCREG_RESET_BYTE;
      start_block_field_q <= `CRCREG_RESET_BYTE;
      block_count_field_q <= `CRCREG_RESET_BYTE;
      auto_check_enable_q <= 1'b0;
    end else begin
      if (wr_in) begin
        data_input_q <= sfr_wdata_i;
      end
      if (wr_cn0) begin
        init_value_select_q <= preset_all_one;
      end
      if (wr_flip) begin
        bit_reverse_reg_q <= reversed_byte;
      end
      if (wr_start) begin
        start_block_field_q <= sfr_wdata_i;
      end
      if (wr_count) begin
        block_count_field_q <= sfr_wdata_i;
      end
      if (wr_cn1) begin
        auto_check_enable_q <= sfr_wdata_i[`CRCREG_BIT_AUTO_CHECK_ENABLE];
      end
    end
  end

  // Flash walk: one byte per request, whole 256-byte blocks
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      remain_q <= 16'h0000;
      flash_rd_o <= 1'b0;
      flash_addr_o <= 16'h0000;
    end else begin
      case (state_q)
        ST_IDLE: begin
          flash_rd_o <= 1'b0;
          // Zero blocks means nothing to walk; no stall
          if (wr_cn0 && auto_check_enable_q && block_count_field_q != 8'h00) begin
            state_q <= ST_REQ;
            // Blocks are 256 bytes, so start and count are the high address byte
            flash_addr_o <= {start_block_field_q, 8'h00};
            remain_q <= {block_count_field_q, 8'h00};
          end
        end
        ST_REQ: begin
          flash_rd_o <= 1'b1;
          state_q <= ST_WAIT;
        end
        ST_WAIT: begin
          // Request is a one-cycle pulse; the flash may answer any number of cycles later
          flash_rd_o <= 1'b0;
          if (walk_fold) begin
            remain_q <= remain_q - 16'h0001;
            flash_addr_o <= flash_addr_o + 16'h0001;
            // Stall drops on the edge that folds the last byte
            state_q <= walk_last ? ST_IDLE : ST_REQ;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          flash_rd_o <= 1'b0;
        end
      endcase
    end
  end

  always @(posedge core_clk_i) begin
    if (rst_i) begin
      sfr_rdata_o <= `CRCREG_RESET_BYTE;
    end else if (rd) begin
      // Reads of other pages leave the last value standing
      case (sfr_addr_i)
        `CRCREG_ADDR_DATA_INPUT: sfr_rdata_o <= data_input_q;
        `CRCREG_ADDR_RESULT_PORT: sfr_rdata_o <= result_sel_byte;
        `CRCREG_ADDR_CONTROL_ZERO: sfr_rdata_o <= {`CRCREG_CN0_RESERVED, 1'b0, init_value_select_q, 1'b0,
                                                   result_byte_pointer_q};
        `CRCREG_ADDR_BIT_REVERSE: sfr_rdata_o <= bit_reverse_reg_q;
        `CRCREG_ADDR_START_BLOCK: sfr_rdata_o <= start_block_field_q;
        `CRCREG_ADDR_BLOCK_COUNT: sfr_rdata_o <= block_count_field_q;
        // Done bit is simply the walk not being busy
        `CRCREG_ADDR_CONTROL_ONE: sfr_rdata_o <= {auto_check_enable_q, ~auto_busy, 6'h00};
        default: sfr_rdata_o <= 8'h00;
      endcase
    end
  end
endmodule // crcreg_engine

// [rtl/crcreg_consts.vh]
// Address map, field positions and reset values of the CRC register block
`ifndef CRCREG_CONSTS_VH
`define CRCREG_CONSTS_VH
`define CRCREG_SFR_PAGE 8'h20
`define CRCREG_ADDR_DATA_INPUT 8'hCA
`define CRCREG_ADDR_RESULT_PORT 8'hCB
`define CRCREG_ADDR_CONTROL_ZERO 8'hCE
`define CRCREG_ADDR_BIT_REVERSE 8'hCF
`define CRCREG_ADDR_START_BLOCK 8'hD2
`define CRCREG_ADDR_BLOCK_COUNT 8'hD3
`define CRCREG_ADDR_CONTROL_ONE 8'h86
`define CRCREG_BIT_INIT 3
`define CRCREG_BIT_VALSEL 2
`define CRCREG_BIT_PTR 0
`define CRCREG_BIT_AUTO_CHECK_ENABLE 7
`define CRCREG_BIT_DONE 6
`define CRCREG_CN0_RESERVED 4'h1
`define CRCREG_POLY 16'h1021
`define CRCREG_PRESET_ZERO 16'h0000
`define CRCREG_PRESET_ONE 16'hFFFF
`define CRCREG_RESET_BYTE 8'h00
`define CRCREG_BLOCK_BYTES 9'h100
`endif

// [rtl/crcreg_byte_step.v]
// Combinational fold of one byte into a 16-bit CRC result
`timescale 1ns/10ps
`include "crcreg_consts.vh"
module crcreg_byte_step (
  input wire [15:0] crc_i,
  input wire [7:0] byte_i,
  output wire [15:0] crc_o
);
  wire [15:0] stage [0:8];
  assign stage[0] = crc_i ^ {byte_i, 8'h00};
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_step
      assign stage[g+1] = stage[g][15] ? ({stage[g][14:0], 1'b0} ^ `CRCREG_POLY)
                                       : {stage[g][14:0], 1'b0};
    end
  endgenerate
  assign crc_o = stage[8];
endmodule // crcreg_byte_step

// [verification/crcreg_engine_checker.sv]
// Port-level assertions of the CRC register block
`timescale 1ns/10ps
module crcreg_engine_checker (
  input wire core_clk_i,
  input wire rst_i,
  input wire [7:0] sfr_page_i,
  input wire [7:0] sfr_addr_i,
  input wire [7:0] sfr_wdata_i,
  input wire sfr_wr_i,
  input wire sfr_rd_i,
  input wire [7:0] sfr_rdata_o,
  input wire cpu_stall_o,
  input wire flash_rd_o,
  input wire [15:0] flash_addr_o,
  input wire [7:0] flash_data_i,
  input wire flash_valid_i
);
  default clocking dcb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);
  wire pg = sfr_page_i == 8'h20;
  wire [7:0] a = sfr_addr_i;
  wire wr = sfr_wr_i && pg;
  wire rd = sfr_rd_i && pg;
  wire [7:0] rv = {sfr_wdata_i[0], sfr_wdata_i[1], sfr_wdata_i[2], sfr_wdata_i[3],
                   sfr_wdata_i[4], sfr_wdata_i[5], sfr_wdata_i[6], sfr_wdata_i[7]};
  logic preset_q = 1'h0;
  logic cn0_wr_q = 1'h0;
  always @(posedge core_clk_i) begin
    cn0_wr_q <= wr && a == 8'hCE;
    if (wr && a == 8'hCE) preset_q <= sfr_wdata_i[2];
  end
  property p_flip;
    (wr && a == 8'hCF) ##2 (rd && a == 8'hCF) |=> sfr_rdata_o == $past(rv, 3);
  endproperty
  a_flip: assert property (p_flip) else $error("flip readback wrong");
  property p_init;
    (wr && a == 8'hCE && sfr_wdata_i[3]) ##2 (rd && a == 8'hCB) |=> sfr_rdata_o == {8{preset_q}};
  endproperty
  a_init: assert property (p_init) else $error("preset value wrong");
  property p_cn0;
    rd && a == 8'hCE |=> sfr_rdata_o[7:4] == 4'h1 && sfr_rdata_o[3] == 1'h0 && sfr_rdata_o[1] == 1'h0;
  endproperty
  a_cn0: assert property (p_cn0) else $error("control zero fixed bits wrong");
  property p_page;
    sfr_rd_i && !pg |=> $stable(sfr_rdata_o);
  endproperty
  a_page: assert property (p_page) else $error("other page read changed data");
  property p_stall_cause;
    $rose(cpu_stall_o) |-> cn0_wr_q;
  endproperty
  a_stall_cause: assert property (p_stall_cause) else $error("stall without start");
  property p_first_req;
    $rose(cpu_stall_o) |=> flash_rd_o && flash_addr_o[7:0] == 8'h00;
  endproperty
  a_first_req: assert property (p_first_req) else $error("first fetch wrong");
  property p_req_stall;
    flash_rd_o |-> cpu_stall_o;
  endproperty
  a_req_stall: assert property (p_req_stall) else $error("fetch outside walk");
  property p_req_pulse;
    flash_rd_o |=> !flash_rd_o;
  endproperty
  a_req_pulse: assert property (p_req_pulse) else $error("fetch not one cycle");
endmodule // crcreg_engine_checker
bind crcreg_engine crcreg_engine_checker u_chk (.core_clk_i(core_clk_i), .rst_i(rst_i),
  .sfr_page_i(sfr_page_i), .sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_wr_i(sfr_wr_i),
  .sfr_rd_i(sfr_rd_i), .sfr_rdata_o(sfr_rdata_o), .cpu_stall_o(cpu_stall_o), .flash_rd_o(flash_rd_o),
  .flash_addr_o(flash_addr_o), .flash_data_i(flash_data_i), .flash_valid_i(flash_valid_i));

// [verification/crcreg_engine_tb.sv]
// Randomised self-checking bench of the CRC register block
`timescale 1ns/10ps
module crcreg_engine_tb;
  logic clk = 0, rst = 1, wr = 0, rd = 0, fv = 0;
  logic [7:0] pg = 8'h20, ad = 0, wd = 0, fd = 0, rv, st, x;
  logic [15:0] crc;
  wire [7:0] rdat;
  wire [15:0] fa;
  wire stall, frd;
  integer seed = 97, n_errors = 0, n_tests = 0, k = 0, i, m;
  crcreg_engine dut (.core_clk_i(clk), .rst_i(rst), .sfr_page_i(pg), .sfr_addr_i(ad), .sfr_wdata_i(wd),
    .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_rdata_o(rdat), .cpu_stall_o(stall), .flash_rd_o(frd),
    .flash_addr_o(fa), .flash_data_i(fd), .flash_valid_i(fv));
  initial forever #50 clk = ~clk;
  function automatic [15:0] step(input [15:0] c, input [7:0] b);
    step = c ^ {b, 8'h00};
    for (int j = 0; j < 8; j++) step = step[15] ? {step[14:0], 1'h0} ^ 16'h1021 : {step[14:0], 1'h0};
  endfunction
  function automatic [7:0] rev(input [7:0] b);
    for (int j = 0; j < 8; j++) rev[j] = b[7 - j];
  endfunction
  task chk(input string nm, input [15:0] e, input [15:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wrr(input [7:0] a, input [7:0] d);
    @(posedge clk);
    ad <= a;
    wd <= d;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
  endtask
  task rdr(input [7:0] a);
    @(posedge clk);
    ad <= a;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    #1 rv = rdat;
  endtask
  task test_done;
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Flash side answers every fetch one cycle later
  always @(posedge clk) begin
    fv <= frd;
    fd <= fa[7:0] ^ 8'h5A;
    if (frd) begin
      chk("flash_addr", {st, k[7:0]}, fa);
      k = k + 1;
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 0;
    rdr(8'hCE);
    chk("cn0_reset", 16'h0010, rv);
    for (i = 0; i < 5; i++) begin
      x = i == 0 ? 8'hC0 : i == 1 ? 8'h05 : $random(seed);
      wrr(8'hCF, x);
      rdr(8'hCF);
      chk("flip", rev(x), rv);
      rdr(8'hCF);
      chk("flip_again", rev(x), rv);
    end
    @(posedge clk) pg <= 8'h21;
    rdr(8'hCF);
    // Another page's read leaves the last value standing
    chk("other_page", rev(x), rv);
    @(posedge clk) pg <= 8'h20;
    for (i = 0; i < 2; i++) begin
      wrr(8'hCE, {4'h1, 1'h1, i[0], 2'h0});
      crc = i ? 16'hFFFF : 16'h0000;
      // One idle cycle after init before the result is read
      repeat (2) begin
        rdr(8'hCB);
        chk("preset", {8{i[0]}}, rv);
      end
      for (m = 0; m < 6; m++) begin
        x = m == 0 ? 8'h63 : $random(seed);
        wrr(8'hCA, x);
        crc = step(crc, x);
      end
      rdr(8'hCA);
      chk("data_in", x, rv);
      rdr(8'hCB);
      chk("result_lo", crc[7:0], rv);
      rdr(8'hCB);
      chk("result_hi", crc[15:8], rv);
    end
    st = $random(seed);
    wrr(8'hD2, st);
    wrr(8'hD3, 8'h01);
    wrr(8'h86, 8'h80);
    wrr(8'hCE, 8'h10);
    for (i = 0; i < 256; i++) crc = step(crc, i[7:0] ^ 8'h5A);
    #1;
    // Bus stays idle while the walk stalls the core
    for (i = 0; i < 2000 && stall !== 1'h0; i++) @(posedge clk);
    chk("walk_end", 1'h0, stall);
    chk("blocks", 16'h0100, k[15:0]);
    rdr(8'h86);
    chk("cn1_done", 16'h00C0, rv);
    rdr(8'hD2);
    chk("start_blk", st, rv);
    wrr(8'h86, 8'h00);
    rdr(8'hCB);
    chk("auto_lo", crc[7:0], rv);
    rdr(8'hCB);
    chk("auto_hi", crc[15:8], rv);
    // A port write replaces the selected low byte and moves the pointer on
    wrr(8'hCB, 8'hA5);
    rdr(8'hCB);
    chk("port_wr_hi", crc[15:8], rv);
    rdr(8'hCB);
    chk("port_wr_lo", 16'h00A5, rv);
    test_done;
  end
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    test_done;
  end
endmodule // crcreg_engine_tb
